// File: rtl/fsc_fan_ctrl.sv
// Two-fan tach measurement, PWM/DC drive and closed-loop regulation
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Contract
// [RULE1] Speed counts readable at indices 28h, 29h
// [RULE2] Count measures time between tach pulses
// [RULE3] Three-bit divisor per fan, reset divisor two
// [RULE4] Divisor is two to the encoded power
// [RULE5] Per-fan PWM or DC output select
// [RULE6] PWM duty equals value over 255
// [RULE7] Output value resets to full scale
// [RULE8] PWM carrier rate from per-fan register
// [RULE9] DC mode drives upper six value bits
// [RULE10] DC reset code all ones
// [RULE11] Closed loop starts from held value
// [RULE12] Temperature source per fan selectable
// [RULE13] Fan off below low end, start value
// [RULE14] Above high end raise; warn at full
// [RULE15] Inside window hold output
// [RULE16] Below low end lower to zero/stop
// [RULE17] Hold stop value for stop time
// [RULE18] Speed loop pairs tach with output
// [RULE19] Speed loop raises, lowers or holds
// [RULE20] One step per interval, saturating
module fsc_fan_ctrl
  import fsc_pkg::*;
#(
  parameter int TACH_TICK_CYCLES = FSC_TACH_TICK_CYC,
  parameter int UNIT_CYCLES = FSC_STEP_UNIT_CYC
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic system_fan_tach_input,
  input wire logic processor_fan_tach_input,
  input wire logic [7:0] system_temperature_input,
  input wire logic [7:0] processor_temperature_input,
  input wire logic [47:0] aux_temperature_inputs,
  output logic system_fan_output,
  output logic [5:0] system_fan_dac,
  output logic processor_fan_output,
  output logic [5:0] processor_fan_dac,
  output logic system_fan_warning,
  output logic processor_fan_warning
);

  logic [7:0] freq_reg [2];
  logic [7:0] val_reg [2];
  logic [7:0] tgt_reg [2];
  logic [7:0] start_reg [2];
  logic [7:0] stopv_reg [2];
  logic [7:0] stopt_reg [2];
  logic [7:0] cnt_reg [2];
  logic [7:0] type_reg, tol_reg, step_dn_reg, step_up_reg, stop_en_reg;
  logic [7:0] div_lo_reg, div_hi_reg, src_cpu_reg, src_sys_reg, mode_reg;
  logic [31:0] prdata_reg;
  logic err_reg;
  logic [7:0] rd_next;
  logic hit;
  logic [1:0] warn_reg;
  logic [1:0] off_flag;
  logic [1:0] pwm_q;
  logic [5:0] dac_q [2];
  logic [7:0] temps [8];
  logic [1:0] tach_pin;

  // APB decode; answer in the first access cycle
  logic setup, wr_en, addr_ok;
  logic [6:0] idx;
  assign setup = psel & ~penable;
  assign idx = paddr[8:2];
  assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[11:9] == 3'h0);
  assign wr_en = psel & penable & pwrite & ~err_reg;
  assign pready = 1'b1;
  assign pslverr = psel & penable & err_reg;
  assign prdata = prdata_reg;

  always_comb
  begin
    hit = 1'b1;
    rd_next = 8'h00;
    case (idx)
      FSC_IDX_FREQ_A: rd_next = freq_reg[0];
      FSC_IDX_VAL_A: rd_next = val_reg[0];
      FSC_IDX_FREQ_B: rd_next = freq_reg[1];
      FSC_IDX_VAL_B: rd_next = val_reg[1];
      FSC_IDX_TYPE: rd_next = type_reg;
      FSC_IDX_TGT_A: rd_next = tgt_reg[0];
      FSC_IDX_TGT_B: rd_next = tgt_reg[1];
      FSC_IDX_TOL: rd_next = tol_reg;
      FSC_IDX_STOPV_A: rd_next = stopv_reg[0];
      FSC_IDX_STOPV_B: rd_next = stopv_reg[1];
      FSC_IDX_START_A: rd_next = start_reg[0];
      FSC_IDX_START_B: rd_next = start_reg[1];
      FSC_IDX_STOPT_A: rd_next = stopt_reg[0];
      FSC_IDX_STOPT_B: rd_next = stopt_reg[1];
      FSC_IDX_STEP_DN: rd_next = step_dn_reg;
      FSC_IDX_STEP_UP: rd_next = step_up_reg;
      FSC_IDX_STOP_EN: rd_next = stop_en_reg;
      FSC_IDX_SYS_TEMP: rd_next = system_temperature_input;
      FSC_IDX_CNT_A: rd_next = cnt_reg[0]; // see [RULE1]
      FSC_IDX_CNT_B: rd_next = cnt_reg[1]; // see [RULE1]
      FSC_IDX_DIV_LO: rd_next = div_lo_reg;
      FSC_IDX_SRC_CPU: rd_next = src_cpu_reg;
      FSC_IDX_SRC_SYS: rd_next = src_sys_reg;
      FSC_IDX_CPU_TEMP_HI: rd_next = temps[src_cpu_reg[2:0]];
      FSC_IDX_CPU_TEMP_LO: rd_next = 8'h00;
      FSC_IDX_DIV_HI: rd_next = div_hi_reg;
      FSC_IDX_MODE: rd_next = mode_reg;
      FSC_IDX_STATUS: rd_next = {4'h0, off_flag, warn_reg};
      default: hit = 1'b0;
    endcase
  end

  // Read data and error captured in the setup cycle
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      prdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
    end
    else if (setup)
    begin
      prdata_reg <= {24'h00_0000, rd_next};
      err_reg <= ~(hit & addr_ok);
    end
  end

  // Configuration registers
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 2; i++)
      begin
        freq_reg[i] <= FSC_ZERO_RST;
        tgt_reg[i] <= FSC_ZERO_RST;
        start_reg[i] <= FSC_ZERO_RST;
        stopv_reg[i] <= FSC_ZERO_RST;
        stopt_reg[i] <= FSC_ZERO_RST;
      end
      type_reg <= FSC_ZERO_RST;
      tol_reg <= FSC_ZERO_RST;
      step_dn_reg <= FSC_ZERO_RST;
      step_up_reg <= FSC_ZERO_RST;
      stop_en_reg <= FSC_ZERO_RST;
      div_lo_reg <= FSC_DIV_LO_RST; // see [RULE3]
      div_hi_reg <= FSC_ZERO_RST;
      src_cpu_reg <= FSC_ZERO_RST;
      src_sys_reg <= FSC_ZERO_RST;
      mode_reg <= FSC_ZERO_RST;
    end
    else if (wr_en)
    begin
      case (idx)
        FSC_IDX_FREQ_A: freq_reg[0] <= pwdata[7:0];
        FSC_IDX_FREQ_B: freq_reg[1] <= pwdata[7:0];
        FSC_IDX_TYPE: type_reg <= pwdata[7:0];
        FSC_IDX_TGT_A: tgt_reg[0] <= pwdata[7:0];
        FSC_IDX_TGT_B: tgt_reg[1] <= pwdata[7:0];
        FSC_IDX_TOL: tol_reg <= pwdata[7:0];
        FSC_IDX_STOPV_A: stopv_reg[0] <= pwdata[7:0];
        FSC_IDX_STOPV_B: stopv_reg[1] <= pwdata[7:0];
        FSC_IDX_START_A: start_reg[0] <= pwdata[7:0];
        FSC_IDX_START_B: start_reg[1] <= pwdata[7:0];
        FSC_IDX_STOPT_A: stopt_reg[0] <= pwdata[7:0];
        FSC_IDX_STOPT_B: stopt_reg[1] <= pwdata[7:0];
        FSC_IDX_STEP_DN: step_dn_reg <= pwdata[7:0];
        FSC_IDX_STEP_UP: step_up_reg <= pwdata[7:0];
        FSC_IDX_STOP_EN: stop_en_reg <= pwdata[7:0];
        FSC_IDX_DIV_LO: div_lo_reg <= pwdata[7:0];
        FSC_IDX_SRC_CPU: src_cpu_reg <= pwdata[7:0];
        FSC_IDX_SRC_SYS: src_sys_reg <= pwdata[7:0];
        FSC_IDX_DIV_HI: div_hi_reg <= pwdata[7:0];
        FSC_IDX_MODE: mode_reg <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Shared time bases: tach count tick and step/stop unit tick
  logic [31:0] tach_div, unit_div;
  logic tach_tick, unit_tick;
  assign tach_tick = (tach_div == 32'(TACH_TICK_CYCLES - 1));
  assign unit_tick = (unit_div == 32'(UNIT_CYCLES - 1));

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      tach_div <= 32'h0000_0000;
    else if (tach_tick)
      tach_div <= 32'h0000_0000;
    else
      tach_div <= tach_div + 32'h0000_0001;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      unit_div <= 32'h0000_0000;
    else if (unit_tick)
      unit_div <= 32'h0000_0000;
    else
      unit_div <= unit_div + 32'h0000_0001;
  end

  // Temperature sources selectable per fan
  assign temps[0] = system_temperature_input;
  assign temps[1] = processor_temperature_input;
  assign tach_pin = {processor_fan_tach_input, system_fan_tach_input};

  genvar g;
  generate
    for (g = 0; g < 6; g++)
    begin : g_aux
      assign temps[g + 2] = aux_temperature_inputs[g * 8 +: 8];
    end

    for (g = 0; g < 2; g++)
    begin : g_fan
      logic s1, s2, s3, rise;
      logic [2:0] div_sel;
      logic [7:0] div_lim, div_cnt, time_cnt;
      logic [7:0] pre_cnt, pwm_cnt;
      logic [1:0] mode;
      logic [3:0] tol;
      logic [2:0] src;
      logic [7:0] meas;
      logic above, below, stop_en, wr_val, up_due, dn_due;
      logic [7:0] step_cnt, hold_cnt;
      fsc_loop_t state;

      // Tach synchroniser and edge detect
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
        end
        else
        begin
          s1 <= tach_pin[g];
          s2 <= s1;
          s3 <= s2;
        end
      end
      assign rise = s2 & ~s3;

      // Divisor code {bit2, bits1..0} is the power of two directly
      assign div_sel = (g == 0)
        ? {div_hi_reg[FSC_DIV_HI_POS_A], div_lo_reg[FSC_DIV_LO_POS_A +: 2]}
        : {div_hi_reg[FSC_DIV_HI_POS_B], div_lo_reg[FSC_DIV_LO_POS_B +: 2]};
      assign div_lim = ~(FSC_FULL << div_sel); // see [RULE4]

      // Time between tach edges, saturating
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          div_cnt <= FSC_ZERO_RST;
          time_cnt <= FSC_ZERO_RST;
          cnt_reg[g] <= FSC_ZERO_RST;
        end
        else if (rise)
        begin
          cnt_reg[g] <= time_cnt; // see [RULE2]
          time_cnt <= FSC_ZERO_RST;
          div_cnt <= FSC_ZERO_RST;
        end
        else if (tach_tick)
        begin
          if (div_cnt == div_lim) // see [RULE3]
          begin
            div_cnt <= FSC_ZERO_RST;
            if (time_cnt != FSC_FULL)
              time_cnt <= time_cnt + 8'h01; // see [RULE2]
          end
          else
            div_cnt <= div_cnt + 8'h01;
        end
      end

      // PWM carrier: prescale by register, 255 slots per period
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          pre_cnt <= FSC_ZERO_RST;
          pwm_cnt <= FSC_ZERO_RST;
        end
        else if (pre_cnt >= freq_reg[g]) // see [RULE8]
        begin
          pre_cnt <= FSC_ZERO_RST;
          pwm_cnt <= (pwm_cnt >= FSC_PWM_TOP) ? FSC_ZERO_RST
                                              : pwm_cnt + 8'h01;
        end
        else
          pre_cnt <= pre_cnt + 8'h01;
      end

      // Output stage: PWM pin or DAC code
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          pwm_q[g] <= 1'b1;
          dac_q[g] <= 6'h00;
        end
        else
        begin
          pwm_q[g] <= ~type_reg[g] & (pwm_cnt < val_reg[g]); // see [RULE6]
          dac_q[g] <= type_reg[g] ? val_reg[g][7:2] : 6'h00; // see [RULE9]
        end
      end

      // Loop inputs
      assign mode = mode_reg[2 * g +: 2];
      assign tol = (g == 0) ? tol_reg[3:0] : tol_reg[7:4];
      assign src = (g == 0) ? src_sys_reg[FSC_SRC_SYS_POS +: 3]
                            : src_cpu_reg[FSC_SRC_CPU_POS +: 3];
      assign meas = (mode == FSC_MODE_THERMAL) ? temps[src] // see [RULE12]
                                               : cnt_reg[g]; // see [RULE18]
      assign above = {1'b0, meas} > ({1'b0, tgt_reg[g]} + {5'h00, tol});
      assign below = ({1'b0, meas} + {5'h00, tol}) < {1'b0, tgt_reg[g]};
      assign stop_en = stop_en_reg[(g == 0) ? FSC_STOP_EN_POS_A
                                            : FSC_STOP_EN_POS_B];
      assign wr_val = wr_en && (idx == ((g == 0) ? FSC_IDX_VAL_A
                                                 : FSC_IDX_VAL_B));
      assign up_due = step_cnt >= step_up_reg;
      assign dn_due = step_cnt >= step_dn_reg;
      assign off_flag[g] = (state == FSC_OFF);

      // Regulation loop and output value register
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          val_reg[g] <= FSC_VAL_RST; // see [RULE7] see [RULE10]
          state <= FSC_RUN;
          step_cnt <= FSC_ZERO_RST;
          hold_cnt <= FSC_ZERO_RST;
          warn_reg[g] <= 1'b0;
        end
        else
        begin
          warn_reg[g] <= (mode == FSC_MODE_THERMAL) && (state == FSC_RUN)
                         && above && (val_reg[g] == FSC_FULL); // see [RULE14]
          if (unit_tick && (step_cnt != FSC_FULL))
            step_cnt <= step_cnt + 8'h01;
          if (wr_val)
            val_reg[g] <= pwdata[7:0];
          else if (mode == FSC_MODE_THERMAL)
          begin
            case (state)
              FSC_OFF:
              begin
                val_reg[g] <= FSC_ZERO_RST; // see [RULE13]
                if (!below)
                begin
                  val_reg[g] <= start_reg[g]; // see [RULE13]
                  state <= FSC_RUN;
                end
              end
              FSC_RUN:
              begin
                // Entered with the held value; see [RULE11]
                if (above && up_due)
                begin
                  step_cnt <= FSC_ZERO_RST; // see [RULE20]
                  if (val_reg[g] != FSC_FULL)
                    val_reg[g] <= val_reg[g] + 8'h01; // see [RULE14]
                end
                else if (below && dn_due)
                begin
                  step_cnt <= FSC_ZERO_RST; // see [RULE20]
                  if (stop_en && (val_reg[g] <= stopv_reg[g]))
                  begin
                    val_reg[g] <= stopv_reg[g]; // see [RULE16]
                    hold_cnt <= FSC_ZERO_RST;
                    state <= FSC_HOLD;
                  end
                  else if (val_reg[g] == FSC_ZERO_RST)
                    state <= FSC_OFF; // see [RULE16]
                  else
                    val_reg[g] <= val_reg[g] - 8'h01; // see [RULE16]
                end
                // Inside the window nothing changes; see [RULE15]
              end
              FSC_HOLD:
              begin
                if (!below)
                  state <= FSC_RUN;
                else if (unit_tick)
                begin
                  if (hold_cnt >= stopt_reg[g]) // see [RULE17]
                  begin
                    val_reg[g] <= FSC_ZERO_RST;
                    state <= FSC_OFF;
                  end
                  else
                    hold_cnt <= hold_cnt + 8'h01;
                end
              end
              default: state <= FSC_RUN;
            endcase
          end
          else if (mode == FSC_MODE_SPEED)
          begin
            state <= FSC_RUN;
            if (above && up_due)
            begin
              step_cnt <= FSC_ZERO_RST;
              if (val_reg[g] != FSC_FULL)
                val_reg[g] <= val_reg[g] + 8'h01; // see [RULE19] [RULE20]
            end
            else if (below && dn_due)
            begin
              step_cnt <= FSC_ZERO_RST;
              if (val_reg[g] != FSC_ZERO_RST)
                val_reg[g] <= val_reg[g] - 8'h01; // see [RULE19] [RULE20]
            end
          end
          else
          begin
            state <= FSC_RUN; // see [RULE11]
            hold_cnt <= FSC_ZERO_RST;
          end
        end
      end
    end
  endgenerate

  // Pin mapping, fan 0 is the system fan; see [RULE5]
  assign system_fan_output = pwm_q[0];
  assign processor_fan_output = pwm_q[1];
  assign system_fan_dac = dac_q[0];
  assign processor_fan_dac = dac_q[1];
  assign system_fan_warning = warn_reg[0];
  assign processor_fan_warning = warn_reg[1];

endmodule : fsc_fan_ctrl

`default_nettype wire

// File: rtl/fsc_pkg.sv
// Constants, register indices and types for the fan speed monitor/control
package fsc_pkg;

  // Register indices; byte address on APB is four times the index
  localparam logic [6:0] FSC_IDX_FREQ_A = 7'h00;
  localparam logic [6:0] FSC_IDX_VAL_A = 7'h01;
  localparam logic [6:0] FSC_IDX_FREQ_B = 7'h02;
  localparam logic [6:0] FSC_IDX_VAL_B = 7'h03;
  localparam logic [6:0] FSC_IDX_TYPE = 7'h04;
  localparam logic [6:0] FSC_IDX_TGT_A = 7'h05;
  localparam logic [6:0] FSC_IDX_TGT_B = 7'h06;
  localparam logic [6:0] FSC_IDX_TOL = 7'h07;
  localparam logic [6:0] FSC_IDX_STOPV_A = 7'h08;
  localparam logic [6:0] FSC_IDX_STOPV_B = 7'h09;
  localparam logic [6:0] FSC_IDX_START_A = 7'h0A;
  localparam logic [6:0] FSC_IDX_START_B = 7'h0B;
  localparam logic [6:0] FSC_IDX_STOPT_A = 7'h0C;
  localparam logic [6:0] FSC_IDX_STOPT_B = 7'h0D;
  localparam logic [6:0] FSC_IDX_STEP_DN = 7'h0E;
  localparam logic [6:0] FSC_IDX_STEP_UP = 7'h0F;
  localparam logic [6:0] FSC_IDX_STOP_EN = 7'h12;
  localparam logic [6:0] FSC_IDX_SYS_TEMP = 7'h27;
  localparam logic [6:0] FSC_IDX_CNT_A = 7'h28;
  localparam logic [6:0] FSC_IDX_CNT_B = 7'h29;
  localparam logic [6:0] FSC_IDX_DIV_LO = 7'h47;
  localparam logic [6:0] FSC_IDX_SRC_CPU = 7'h49;
  localparam logic [6:0] FSC_IDX_SRC_SYS = 7'h4A;
  localparam logic [6:0] FSC_IDX_CPU_TEMP_HI = 7'h50;
  localparam logic [6:0] FSC_IDX_CPU_TEMP_LO = 7'h51;
  localparam logic [6:0] FSC_IDX_DIV_HI = 7'h5D;
  localparam logic [6:0] FSC_IDX_MODE = 7'h70;
  localparam logic [6:0] FSC_IDX_STATUS = 7'h71;

  // Reset values, full-scale limit and PWM counter top
  localparam logic [7:0] FSC_VAL_RST = 8'hFF;
  localparam logic [7:0] FSC_DIV_LO_RST = 8'h50;
  localparam logic [7:0] FSC_ZERO_RST = 8'h00;
  localparam logic [7:0] FSC_FULL = 8'hFF;
  localparam logic [7:0] FSC_PWM_TOP = 8'hFE;

  // Field positions
  localparam int FSC_DIV_LO_POS_A = 4;
  localparam int FSC_DIV_LO_POS_B = 6;
  localparam int FSC_DIV_HI_POS_A = 5;
  localparam int FSC_DIV_HI_POS_B = 6;
  localparam int FSC_STOP_EN_POS_A = 5;
  localparam int FSC_STOP_EN_POS_B = 4;
  localparam int FSC_SRC_SYS_POS = 5;
  localparam int FSC_SRC_CPU_POS = 0;

  // Loop modes, two bits per fan in the mode register
  localparam logic [1:0] FSC_MODE_MANUAL = 2'h0;
  localparam logic [1:0] FSC_MODE_THERMAL = 2'h1;
  localparam logic [1:0] FSC_MODE_SPEED = 2'h2;

  // Timing
  localparam int FSC_CLK_NS = 8;
  localparam int FSC_TACH_TICK_NS = 44444;
  localparam int FSC_TACH_TICK_CYC = FSC_TACH_TICK_NS / FSC_CLK_NS;
  localparam int FSC_STEP_UNIT_MS = 100;
  localparam int FSC_STEP_UNIT_CYC = FSC_STEP_UNIT_MS * 1000000 / FSC_CLK_NS;

  typedef enum {FSC_OFF, FSC_RUN, FSC_HOLD} fsc_loop_t;

endpackage : fsc_pkg

// File: testbench/fsc_fan_model.sv
// Behavioural fan whose tachometer output has a programmable period
`timescale 1ns/1ps
`default_nettype none
module fsc_fan_model
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [15:0] half_cycles,
  output logic tach
);
  logic [15:0] cnt_reg;
  // One tach period is two half periods
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_reg <= 16'h0000;
      tach <= 1'b0;
    end
    else if (cnt_reg >= half_cycles - 16'h0001)
    begin
      cnt_reg <= 16'h0000;
      tach <= ~tach;
    end
    else
    begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end
endmodule : fsc_fan_model
`default_nettype wire

// File: testbench/fsc_fan_ctrl_assertions.sv
// Port checker for the fan speed monitor/control block
`timescale 1ns/1ps
`default_nettype none
module fsc_fan_ctrl_assertions
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic system_fan_output,
  input wire logic [5:0] system_fan_dac,
  input wire logic processor_fan_output,
  input wire logic [5:0] processor_fan_dac
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  logic acc;
  assign acc = psel & penable;
  pready_high_a: assert property (psel |-> pready)
    else $error("pready low in a transfer");
  err_phase_a: assert property (pslverr |-> acc)
    else $error("pslverr outside access phase");
  err_misalign_a: assert property (
    acc && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not refused");
  err_upper_a: assert property (
    acc && paddr[11:9] != 3'h0 |-> pslverr)
    else $error("upper address not refused");
  count_noerr_a: assert property (
    acc && paddr == 12'h0A0 |-> !pslverr)
    else $error("speed count access refused");
  rdata_hold_a: assert property (
    !(psel && !penable) |=> $stable(prdata))
    else $error("read data moved outside setup");
  rdata_upper_a: assert property (prdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  sys_dc_excl_a: assert property (
    system_fan_dac != 6'h00 |-> !system_fan_output)
    else $error("system fan drives dac and pwm");
  cpu_dc_excl_a: assert property (
    processor_fan_dac != 6'h00 |-> !processor_fan_output)
    else $error("processor fan drives dac and pwm");
  wr_c: cover property (acc && pwrite && !pslverr);
  err_c: cover property (acc && pslverr);
  dc_c: cover property (system_fan_dac != 6'h00);
endmodule : fsc_fan_ctrl_assertions
bind fsc_fan_ctrl fsc_fan_ctrl_assertions u_chk (.ref_clk(ref_clk),
  .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .system_fan_output(system_fan_output), .system_fan_dac(system_fan_dac),
  .processor_fan_output(processor_fan_output),
  .processor_fan_dac(processor_fan_dac));
`default_nettype wire

// File: testbench/fsc_fan_ctrl_tb.sv
// Self-checking bench for the fan speed monitor/control block
`timescale 1ns/1ps
`default_nettype none
module fsc_fan_ctrl_tb
  import fsc_pkg::*;
;
  typedef struct packed {logic [7:0] lo, hi, se, ce;} fsc_row_t;
  fsc_row_t rows [6] = '{'{8'h00, 8'h00, 8'h64, 8'hC8},
    '{8'hF0, 8'h00, 8'h0C, 8'h19}, '{8'h00, 8'h60, 8'h06, 8'h0C},
    '{8'h50, 8'h60, 8'h03, 8'h06}, '{8'hF0, 8'h60, 8'h01, 8'h02},
    '{8'h50, 8'h00, 8'h32, 8'h64}};
  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic sys_tach, cpu_tach, sys_out, cpu_out, sys_warn, cpu_warn;
  logic [7:0] sys_temp, cpu_temp;
  logic [5:0] sys_dac, cpu_dac;
  int errors, cmp_count;
  fsc_fan_ctrl #(.TACH_TICK_CYCLES(4), .UNIT_CYCLES(20)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .system_fan_tach_input(sys_tach),
    .processor_fan_tach_input(cpu_tach),
    .system_temperature_input(sys_temp),
    .processor_temperature_input(cpu_temp),
    .aux_temperature_inputs(48'h000000000000),
    .system_fan_output(sys_out), .system_fan_dac(sys_dac),
    .processor_fan_output(cpu_out), .processor_fan_dac(cpu_dac),
    .system_fan_warning(sys_warn), .processor_fan_warning(cpu_warn));
  fsc_fan_model u_sys_fan (.ref_clk(ref_clk), .rst(rst),
    .half_cycles(16'h00C8), .tach(sys_tach));
  fsc_fan_model u_cpu_fan (.ref_clk(ref_clk), .rst(rst),
    .half_cycles(16'h0190), .tach(cpu_tach));
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic wrap_up();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_rng(input logic [31:0] got, input logic [7:0] lo,
    input logic [7:0] hi);
    cmp_count++;
    if ((got >= {24'h0, lo} && got <= {24'h0, hi}) !== 1'b1)
    begin
      errors++;
      $display("ERROR %0t: got %0h outside %0h..%0h", $time, got, lo, hi);
    end
  endtask : chk_rng
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [7:0] d, output logic [31:0] q, output logic e);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    @(posedge ref_clk);
    while (pready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge ref_clk);
    end
    if (n >= 50)
    begin
      errors++;
      wrap_up();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [6:0] i, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, {3'h0, i, 2'h0}, d, q, e);
  endtask : wr
  task automatic rd(input logic [6:0] i, output logic [31:0] q);
    logic e;
    apb(1'b0, {3'h0, i, 2'h0}, 8'h00, q, e);
  endtask : rd
  task automatic poll(input logic [6:0] i, input logic [7:0] exp);
    logic [31:0] q;
    int n;
    n = 0;
    do
    begin
      rd(i, q);
      n++;
    end
    while (q !== {24'h0, exp} && n < 5000);
    chk_val(q, {24'h0, exp});
  endtask : poll
  initial
  begin
    logic [31:0] q, hi_n;
    logic e;
    logic [7:0] v;
    logic [7:0] pf [3] = '{8'h00, 8'h01, 8'h03};
    logic [7:0] pv [3] = '{8'h80, 8'h33, 8'h00};
    errors = 0;
    cmp_count = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    sys_temp = 8'h28;
    cpu_temp = 8'h1E;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    rd(FSC_IDX_VAL_A, q);
    chk_val(q, 32'h000000FF);
    rd(FSC_IDX_VAL_B, q);
    chk_val(q, 32'h000000FF);
    rd(FSC_IDX_DIV_LO, q);
    chk_val(q, 32'h00000050);
    chk_val({31'h0, sys_out}, 32'h1);
    chk_val({31'h0, cpu_out}, 32'h1);
    wr(FSC_IDX_TYPE, 8'h01);
    repeat (3) @(posedge ref_clk);
    chk_val({26'h0, sys_dac}, 32'h3F);
    wr(FSC_IDX_VAL_A, 8'h84);
    repeat (3) @(posedge ref_clk);
    chk_val({26'h0, sys_dac}, 32'h21);
    chk_val({31'h0, sys_out}, 32'h0);
    chk_val({26'h0, cpu_dac}, 32'h0);
    wr(FSC_IDX_TYPE, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      wr(FSC_IDX_DIV_LO, rows[i].lo);
      wr(FSC_IDX_DIV_HI, rows[i].hi);
      repeat (2500) @(posedge ref_clk);
      rd(FSC_IDX_CNT_A, q);
      chk_rng(q, rows[i].se - 8'h01, rows[i].se + 8'h01);
      rd(FSC_IDX_CNT_B, q);
      chk_rng(q, rows[i].ce - 8'h01, rows[i].ce + 8'h01);
    end
    for (int i = 0; i < 3; i++)
    begin
      wr(FSC_IDX_FREQ_A, pf[i]);
      wr(FSC_IDX_VAL_A, pv[i]);
      repeat (1100) @(posedge ref_clk);
      hi_n = 32'h0;
      repeat (255 * (pf[i] + 1))
      begin
        @(posedge ref_clk);
        hi_n = hi_n + {31'h0, sys_out};
      end
      chk_val(hi_n, pv[i] * (pf[i] + 32'h1));
    end
    apb(1'b0, 12'h040, 8'h00, q, e);
    chk_val({e, q[30:0]}, 32'h80000000);
    apb(1'b1, 12'h005, 8'h12, q, e);
    chk_val({31'h0, e}, 32'h1);
    apb(1'b1, {3'h0, FSC_IDX_CNT_A, 2'h0}, 8'h00, q, e);
    chk_val({31'h0, e}, 32'h0);
    rd(FSC_IDX_SYS_TEMP, q);
    chk_val(q, 32'h00000028);
    wr(FSC_IDX_TGT_A, 8'h37);
    wr(FSC_IDX_TOL, 8'h23);
    wr(FSC_IDX_START_A, 8'h33);
    wr(FSC_IDX_STEP_DN, 8'h01);
    wr(FSC_IDX_STEP_UP, 8'h01);
    wr(FSC_IDX_SRC_SYS, 8'h20);
    wr(FSC_IDX_STOP_EN, 8'h00);
    wr(FSC_IDX_VAL_A, 8'h04);
    wr(FSC_IDX_MODE, 8'h01);
    poll(FSC_IDX_VAL_A, 8'h00);
    repeat (50) @(posedge ref_clk);
    rd(FSC_IDX_STATUS, q);
    chk_val(q, 32'h00000004);
    cpu_temp <= 8'h36;
    poll(FSC_IDX_VAL_A, 8'h33);
    cpu_temp <= 8'h38;
    repeat (200) @(posedge ref_clk);
    rd(FSC_IDX_VAL_A, q);
    chk_val(q, 32'h00000033);
    cpu_temp <= 8'h3C;
    poll(FSC_IDX_VAL_A, 8'hFF);
    repeat (50) @(posedge ref_clk);
    chk_val({31'h0, sys_warn}, 32'h1);
    chk_val({31'h0, cpu_warn}, 32'h0);
    rd(FSC_IDX_VAL_A, q);
    chk_val(q, 32'h000000FF);
    rd(FSC_IDX_STATUS, q);
    chk_val(q, 32'h00000001);
    wr(FSC_IDX_STOPV_A, 8'h20);
    wr(FSC_IDX_STOPT_A, 8'h02);
    wr(FSC_IDX_STOP_EN, 8'h20);
    cpu_temp <= 8'h28;
    poll(FSC_IDX_VAL_A, 8'h20);
    rd(FSC_IDX_VAL_A, q);
    chk_val(q, 32'h00000020);
    poll(FSC_IDX_VAL_A, 8'h00);
    wr(FSC_IDX_SRC_CPU, 8'h01);
    rd(FSC_IDX_CPU_TEMP_HI, q);
    chk_val(q, 32'h00000028);
    wr(FSC_IDX_MODE, 8'h00);
    wr(FSC_IDX_VAL_B, 8'h40);
    wr(FSC_IDX_TGT_B, 8'h50);
    wr(FSC_IDX_MODE, 8'h08);
    repeat (200) @(posedge ref_clk);
    rd(FSC_IDX_VAL_B, q);
    chk_rng(q, 8'h41, 8'h60);
    v = q[7:0];
    wr(FSC_IDX_TGT_B, 8'h78);
    repeat (200) @(posedge ref_clk);
    rd(FSC_IDX_VAL_B, q);
    chk_rng(q, 8'h00, v - 8'h01);
    // Reset in mid-run sets the loop-driven value back to full scale
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd(FSC_IDX_VAL_B, q);
    chk_val(q, 32'h000000FF);
    chk_val({31'h0, cpu_out}, 32'h1);
    wrap_up();
  end
endmodule : fsc_fan_ctrl_tb
`default_nettype wire
